// ---- verilog/ccfg_defines.vh ----
// Purpose: constants of the crate controller configuration block.
// Assumes: 4-bit data type codes arrive with an 8-bit parameter.
// Notes: definitions only.
`ifndef CCFG_DEFINES_VH
`define CCFG_DEFINES_VH
`define CCFG_DT_WR_CMD 4'h2
`define CCFG_DT_WR_THN 4'h3
`define CCFG_DT_WR_THP 4'h4
`define CCFG_DT_WR_MASK 4'h5
`define CCFG_DT_WR_SHIFT 4'h6
`define CCFG_DT_WR_TEST 4'h7
`define CCFG_DT_EVENT 4'h8
`define CCFG_DT_RD_CMD 4'ha
`define CCFG_DT_RD_THN 4'hb
`define CCFG_DT_RD_THP 4'hc
`define CCFG_DT_RD_MASK 4'hd
`define CCFG_DT_RD_SHIFT 4'he
`define CCFG_DT_RD_TEST 4'hf
`define CCFG_CMD_ACQ 0
`define CCFG_CMD_ROM 1
`define CCFG_CMD_TST 2
`define CCFG_CMD_LED 3
`define CCFG_CMD_RTO 4
`define CCFG_CMD_SOFT_CLEAR 7
`define CCFG_CMD_WMASK 8'h9f
`define CCFG_RB_PIPE 5
`define CCFG_RB_ST1 6
`define CCFG_RB_ST2 7
`define CCFG_SHIFT_MASK 8'h3f
`define CCFG_RESET_BYTE 8'h00
`define CCFG_TRIG_WORDS 8'h06
`endif

// ---- verilog/ccfg_edge.v ----
// Purpose: registered level with rise and fall pulses.
// Assumes: input synchronous to clk_i.
// Notes: used for the pipeline enable level.
module ccfg_edge (
  input wire clk_i,
  input wire reset_i,
  input wire level_i,
  output reg level_o,
  output wire rise_o,
  output wire fall_o
);
  always @(posedge clk_i) begin
    if (reset_i) begin
      level_o <= 1'b0;
    end else begin
      level_o <= level_i;
    end
  end
  assign rise_o = level_i & ~level_o;
  assign fall_o = ~level_i & level_o;
endmodule

// ---- verilog/ccfg_regs.v ----
// Purpose: configuration registers and command logic of the crate controller.
// Assumes: link receiver delivers type/data pulses; read-out engine reports word and cycle end.
// Notes: read-back words leave on tx_* for one cycle.
// Notes on behaviour
// - Types 2..7 write, 10..15 read back.
// - Command word: clear, 0, 0, rto, led, tst, rom, acq.
// - Acquisition shifts while enabled, reads on fall.
// - Re-read starts when pipeline low, self-clears.
// - Test cycle needs pipeline, acquisition low; self-clears.
// - LED bit switches pulse generator.
// - Trigger-only sends six words, then self-clears.
// - Soft clear one-then-zero resets; held disables.
// - Command read-back adds pipeline and diagnostic bits.
// - Two threshold registers, types 3/4, 11/12.
// - Mask bit n enables condition n.
// - Shift count keeps six low bits.
// - Shift count gives shift steps before read-out.
// - Test bits written type 7, read 15.
// - Test bit gives two hits, two channels.
// - Test bit channel and tile mapping table.
// - Test mode conditions equal test bits.
// - Inspection output shows pipeline enable low-active.
// - Three indicators: pipeline, diag low, diag high.
// - Main clock from exactly one source.
// - Data type 4-bit codes, 8 is event.
`include "ccfg_defines.vh"
module ccfg_regs (
  input wire clk_i,
  input wire reset_i,
  input wire rx_valid_i,
  input wire [3:0] rx_type_i,
  input wire [7:0] rx_data_i,
  input wire pipeline_enable_i,
  input wire diag_status_low_i,
  input wire diag_status_high_i,
  input wire word_sent_i,
  input wire readout_done_i,
  input wire [15:0] tile_hits_i,
  input wire [7:0] logic_conditions_i,
  input wire [1:0] clock_select_i,
  input wire fibre_clock_i,
  input wire onboard_osc_clock_i,
  input wire external_clock_in_i,
  output reg tx_valid_o,
  output reg [3:0] tx_type_o,
  output reg [7:0] tx_data_o,
  output reg [7:0] command_word_o,
  output reg [7:0] threshold_code_neg_o,
  output reg [7:0] threshold_code_pos_o,
  output reg [7:0] pipeline_shift_count_o,
  output reg pipeline_shift_o,
  output reg readout_start_o,
  output reg readout_stop_o,
  output reg [1:0] readout_kind_o,
  output reg light_pulse_output_o,
  output reg [15:0] test_inject_o,
  output reg [15:0] tile_emulate_o,
  output reg [7:0] trigger_condition_o,
  output reg pipeline_enable_n_o,
  output reg [2:0] status_led_o,
  output reg main_clock_o,
  output reg board_disabled_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_ACQ = 2'b01;
  localparam ST_ROM = 2'b10;
  localparam ST_TST = 2'b11;
  reg [7:0] cmd_q;
  reg [7:0] cond_mask_q;
  reg [7:0] test_bits_q;
  reg [1:0] state_q;
  reg [7:0] word_cnt_q;
  reg soft_clear_seen_q;
  wire pipe_q;
  wire pipe_rise;
  wire pipe_fall;
  wire held_clear;
  wire cycle_end;
  wire wr;
  wire rd;
  reg [7:0] rd_data;
  reg [7:0] cmd_next;
  reg [15:0] inj;
  reg [7:0] raw_cond;
  integer k;

  ccfg_edge u_pipe (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(pipeline_enable_i),
    .level_o(pipe_q),
    .rise_o(pipe_rise),
    .fall_o(pipe_fall)
  );

  // Codes 0, 1, 9 and the event code 8 fall through both decodes and change nothing.
  assign wr = rx_valid_i && (rx_type_i >= `CCFG_DT_WR_CMD) && (rx_type_i <= `CCFG_DT_WR_TEST);
  assign rd = rx_valid_i && (rx_type_i >= `CCFG_DT_RD_CMD);
  assign held_clear = cmd_q[`CCFG_CMD_SOFT_CLEAR];
  assign cycle_end = (state_q != ST_IDLE) && readout_done_i;

  always @* begin
    case (rx_type_i)
      `CCFG_DT_RD_CMD: rd_data = {diag_status_high_i, diag_status_low_i, pipe_q, cmd_q[4:0]};
      `CCFG_DT_RD_THN: rd_data = threshold_code_neg_o;
      `CCFG_DT_RD_THP: rd_data = threshold_code_pos_o;
      `CCFG_DT_RD_MASK: rd_data = cond_mask_q;
      `CCFG_DT_RD_SHIFT: rd_data = pipeline_shift_count_o & `CCFG_SHIFT_MASK;
      `CCFG_DT_RD_TEST: rd_data = test_bits_q;
      default: rd_data = `CCFG_RESET_BYTE;
    endcase
  end

  // Command next value: self-clearing bits drop at cycle end unless rewritten in that cycle.
  always @* begin
    cmd_next = cmd_q;
    if (cycle_end) begin
      cmd_next[`CCFG_CMD_RTO] = 1'b0;
      if (state_q == ST_ROM) begin
        cmd_next[`CCFG_CMD_ROM] = 1'b0;
      end
      if (state_q == ST_TST) begin
        cmd_next[`CCFG_CMD_TST] = 1'b0;
      end
    end
    if (wr && rx_type_i == `CCFG_DT_WR_CMD) begin
      cmd_next = rx_data_i & `CCFG_CMD_WMASK;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      cmd_q <= `CCFG_RESET_BYTE;
      soft_clear_seen_q <= 1'b0;
      threshold_code_neg_o <= `CCFG_RESET_BYTE;
      threshold_code_pos_o <= `CCFG_RESET_BYTE;
      cond_mask_q <= `CCFG_RESET_BYTE;
      pipeline_shift_count_o <= `CCFG_RESET_BYTE;
      test_bits_q <= `CCFG_RESET_BYTE;
      tx_valid_o <= 1'b0;
      tx_type_o <= 4'h0;
      tx_data_o <= `CCFG_RESET_BYTE;
    end else begin
      tx_valid_o <= rd;
      if (rd) begin
        tx_type_o <= rx_type_i;
        tx_data_o <= rd_data;
      end
      if (soft_clear_seen_q && !cmd_next[`CCFG_CMD_SOFT_CLEAR]) begin
        cmd_q <= `CCFG_RESET_BYTE;
      end else begin
        cmd_q <= cmd_next;
      end
      soft_clear_seen_q <= cmd_next[`CCFG_CMD_SOFT_CLEAR];
      if (wr) begin
        case (rx_type_i)
          `CCFG_DT_WR_THN: threshold_code_neg_o <= rx_data_i;
          `CCFG_DT_WR_THP: threshold_code_pos_o <= rx_data_i;
          `CCFG_DT_WR_MASK: cond_mask_q <= rx_data_i;
          `CCFG_DT_WR_SHIFT: pipeline_shift_count_o <= rx_data_i & `CCFG_SHIFT_MASK;
          `CCFG_DT_WR_TEST: test_bits_q <= rx_data_i;
          default: threshold_code_neg_o <= threshold_code_neg_o;
        endcase
      end
    end
  end

  // Read-out cycle sequencer; soft clear held forces it idle.
  always @(posedge clk_i) begin
    if (reset_i || held_clear) begin
      state_q <= ST_IDLE;
      word_cnt_q <= `CCFG_RESET_BYTE;
      readout_start_o <= 1'b0;
      readout_stop_o <= 1'b0;
      readout_kind_o <= ST_IDLE;
      pipeline_shift_o <= 1'b0;
    end else begin
      readout_start_o <= 1'b0;
      readout_stop_o <= 1'b0;
      pipeline_shift_o <= cmd_q[`CCFG_CMD_ACQ] && pipe_q;
      case (state_q)
        ST_IDLE: begin
          word_cnt_q <= `CCFG_RESET_BYTE;
          if (cmd_q[`CCFG_CMD_ACQ] && pipe_fall) begin
            state_q <= ST_ACQ;
            readout_start_o <= 1'b1;
            readout_kind_o <= ST_ACQ;
          end else if (cmd_q[`CCFG_CMD_ROM] && !pipeline_enable_i) begin
            state_q <= ST_ROM;
            readout_start_o <= 1'b1;
            readout_kind_o <= ST_ROM;
          end else if (cmd_q[`CCFG_CMD_TST] && !pipeline_enable_i && !cmd_q[`CCFG_CMD_ACQ]) begin
            state_q <= ST_TST;
            readout_start_o <= 1'b1;
            readout_kind_o <= ST_TST;
          end
        end
        ST_ACQ, ST_ROM, ST_TST: begin
          if (word_sent_i && word_cnt_q != `CCFG_TRIG_WORDS) begin
            word_cnt_q <= word_cnt_q + 8'h01;
          end
          // The stop asks the engine to end early; cycle end still comes from it.
          if (cmd_q[`CCFG_CMD_RTO] && word_sent_i && word_cnt_q == `CCFG_TRIG_WORDS - 8'h01) begin
            readout_stop_o <= 1'b1;
          end
          if (readout_done_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Test injection: bit n to channels n and n+8, bit 7 to 0 and 15.
  always @* begin
    inj = 16'h0000;
    for (k = 0; k < 7; k = k + 1) begin
      inj[k] = test_bits_q[k];
      inj[k + 8] = test_bits_q[k];
    end
    inj[0] = test_bits_q[0] | test_bits_q[7];
    inj[15] = test_bits_q[7];
    raw_cond = cmd_q[`CCFG_CMD_TST] ? test_bits_q : logic_conditions_i;
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      test_inject_o <= 16'h0000;
      tile_emulate_o <= 16'h0000;
      trigger_condition_o <= `CCFG_RESET_BYTE;
      light_pulse_output_o <= 1'b0;
      pipeline_enable_n_o <= 1'b1;
      status_led_o <= 3'h0;
      main_clock_o <= 1'b0;
      command_word_o <= `CCFG_RESET_BYTE;
      board_disabled_o <= 1'b0;
    end else begin
      test_inject_o <= inj;
      for (k = 0; k < 4; k = k + 1) begin
        // Tiles a,c of group k+1 from even bit, b,d from odd bit; OR with real hits.
        tile_emulate_o[4*k] <= tile_hits_i[4*k] | test_bits_q[2*k];
        tile_emulate_o[4*k+2] <= tile_hits_i[4*k+2] | test_bits_q[2*k];
        tile_emulate_o[4*k+1] <= tile_hits_i[4*k+1] | test_bits_q[2*k+1];
        tile_emulate_o[4*k+3] <= tile_hits_i[4*k+3] | test_bits_q[2*k+1];
      end
      trigger_condition_o <= raw_cond & cond_mask_q;
      light_pulse_output_o <= cmd_q[`CCFG_CMD_LED] && !held_clear;
      pipeline_enable_n_o <= ~pipe_q;
      status_led_o <= {diag_status_high_i, diag_status_low_i, pipe_q};
      command_word_o <= cmd_q;
      board_disabled_o <= held_clear;
      // Sampled selection keeps exactly one source live; an invalid code picks the fibre clock.
      case (clock_select_i)
        2'b01: main_clock_o <= onboard_osc_clock_i;
        2'b10: main_clock_o <= external_clock_in_i;
        default: main_clock_o <= fibre_clock_i;
      endcase
    end
  end
endmodule

// ---- verification/ccfg_regs_checker.sv ----
// Purpose: port properties of the configuration block.
// Assumes: one clock, synchronous active-high reset.
// Notes: bound from the bench top file.
module ccfg_regs_checker (
  input wire clk_i,
  input wire reset_i,
  input wire rx_valid_i,
  input wire [3:0] rx_type_i,
  input wire [7:0] rx_data_i,
  input wire pipeline_enable_i,
  input wire tx_valid_o,
  input wire [3:0] tx_type_o,
  input wire [7:0] tx_data_o,
  input wire [7:0] command_word_o,
  input wire [7:0] threshold_code_neg_o,
  input wire [7:0] pipeline_shift_count_o,
  input wire pipeline_enable_n_o,
  input wire [2:0] status_led_o,
  input wire board_disabled_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire rd_req = rx_valid_i && rx_type_i >= 4'ha;
  wire wr_cmd = rx_valid_i && rx_type_i == 4'h2;
  property p_rd; rd_req |=> tx_valid_o && tx_type_o == $past(rx_type_i); endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_nord; !rd_req |=> !tx_valid_o; endproperty
  a_nord: assert property (p_nord) else $error("stray read answer");
  property p_cmdrb; rx_valid_i && rx_type_i == 4'ha |=> tx_data_o[4:0] == $past(command_word_o[4:0]); endproperty
  a_cmdrb: assert property (p_cmdrb) else $error("command read wrong");
  property p_thr; rx_valid_i && rx_type_i == 4'h3 |=> threshold_code_neg_o == $past(rx_data_i); endproperty
  a_thr: assert property (p_thr) else $error("threshold wrong");
  property p_shift; rx_valid_i && rx_type_i == 4'h6 |=> pipeline_shift_count_o == ($past(rx_data_i) & 8'h3f); endproperty
  a_shift: assert property (p_shift) else $error("shift count wrong");
  // The command output trails the register by one stage, so writes show two edges later.
  property p_cmd; wr_cmd && !rx_data_i[7] && !board_disabled_o |-> ##2 command_word_o == ($past(rx_data_i, 2) & 8'h1f);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command word wrong");
  property p_soft_clear; wr_cmd && rx_data_i[7] |-> ##2 board_disabled_o; endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("board not disabled");
  property p_sclr0; wr_cmd && !rx_data_i[7] && board_disabled_o |-> ##2 command_word_o == 8'h00 && !board_disabled_o;
  endproperty
  a_sclr0: assert property (p_sclr0) else $error("soft clear incomplete");
  property p_insp; $stable(pipeline_enable_i) [*3] |-> pipeline_enable_n_o != status_led_o[0]; endproperty
  a_insp: assert property (p_insp) else $error("pipeline indicators wrong");
  c_rd: cover property (rd_req);
  c_soft_clear: cover property (wr_cmd && rx_data_i[7]);
  c_fall: cover property (pipeline_enable_i ##1 !pipeline_enable_i);
endmodule

// ---- verification/ccfg_master_model.sv ----
// Purpose: remote master sending typed parameters.
// Assumes: called from the bench at falling edges.
// Notes: idle lines carry the inverse so a stale value never looks fresh.
module ccfg_master_model (
  input wire clk_i,
  output logic rx_valid_o,
  output logic [3:0] rx_type_o,
  output logic [7:0] rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid_o = 1'b0;
    rx_type_o = 4'h0;
    rx_data_o = 8'h00;
  end
  task automatic send(input logic [3:0] t, input logic [7:0] d);
    @(negedge clk_i);
    rx_valid_o <= 1'b1;
    rx_type_o <= t;
    rx_data_o <= d;
    @(negedge clk_i);
    rx_valid_o <= 1'b0;
    rx_type_o <= ~t;
    rx_data_o <= ~d;
  endtask
endmodule

// ---- verification/ccfg_regs_tb.sv ----
// Purpose: self-checking bench of the configuration block.
// Assumes: master model drives the receive side at falling edges.
// Notes: read answers are matched in order through a queue.
module ccfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_i = 1'b1, pe = 1'b0, dlo = 1'b1, dhi = 1'b0, ws = 1'b0, rdone = 1'b0, rxv;
  logic [3:0] rxt;
  logic [7:0] rxd, v;
  logic [7:0] regs [3:7];
  logic [15:0] hits = 16'h0000;
  logic [7:0] lc = 8'h00;
  logic [1:0] csel = 2'b00;
  wire mclk;
  wire [15:0] te;
  logic [7:0] expq [$];
  wire txv, rs, rst, led, shf;
  wire [7:0] txd, cmd, tc;
  wire [1:0] kind;
  wire [15:0] inj;
  int n_errors = 0, cmp_count = 0, cyc = 0, i, n;
  always #2 clk_i = ~clk_i;
  ccfg_master_model m_u (.clk_i(clk_i), .rx_valid_o(rxv), .rx_type_o(rxt), .rx_data_o(rxd));
  ccfg_regs dut_u (.clk_i(clk_i), .reset_i(reset_i), .rx_valid_i(rxv), .rx_type_i(rxt), .rx_data_i(rxd),
    .pipeline_enable_i(pe), .diag_status_low_i(dlo), .diag_status_high_i(dhi), .word_sent_i(ws),
    .readout_done_i(rdone), .tile_hits_i(hits), .logic_conditions_i(lc), .clock_select_i(csel),
    .fibre_clock_i(1'b0), .onboard_osc_clock_i(1'b1), .external_clock_in_i(1'b0), .tx_valid_o(txv),
    .tx_type_o(), .tx_data_o(txd), .command_word_o(cmd), .threshold_code_neg_o(), .threshold_code_pos_o(),
    .pipeline_shift_count_o(), .pipeline_shift_o(shf), .readout_start_o(rs), .readout_stop_o(rst),
    .readout_kind_o(kind), .light_pulse_output_o(led), .test_inject_o(inj), .tile_emulate_o(te),
    .trigger_condition_o(tc), .pipeline_enable_n_o(), .status_led_o(), .main_clock_o(mclk), .board_disabled_o());
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task rd(input logic [3:0] t, input logic [7:0] e);
    expq.push_back(e);
    m_u.send(t, 8'h5a);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      results;
    end
    if (txv === 1'b1) begin
      if (expq.size() > 0) chk(txd, expq.pop_front());
      else chk(16'h0001, 16'h0000);
    end
  end
  initial begin
    i = $urandom(32'h4009);
    hits = $urandom;
    lc = $urandom;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    m_u.send(4'h2, 8'h80);
    m_u.send(4'h2, 8'h00);
    rd(4'ha, {dhi, dlo, 6'h00});
    $display("test soft_clear done");
    for (i = 3; i <= 7; i++) begin
      v = $urandom;
      regs[i] = (i == 6) ? v & 8'h3f : v;
      m_u.send(i[3:0], v);
      rd(i[3:0] + 4'h8, regs[i]);
    end
    chk(inj, {regs[7][7], regs[7][6:0], 1'b0, regs[7][6:1], regs[7][0] | regs[7][7]});
    chk(tc, lc & regs[5]);
    for (n = 0; n < 16; n++) chk(te[n], hits[n] | regs[7][2 * (n / 4) + n % 2]);
    csel = 2'b01;
    repeat (2) @(negedge clk_i);
    chk(mclk, 1'b1);
    csel = 2'b10;
    repeat (2) @(negedge clk_i);
    chk(mclk, 1'b0);
    csel = 2'b00;
    $display("test registers done");
    for (i = 0; i < 4; i++) m_u.send({i[1], 2'b00, i[0]}, ~regs[3]);
    rd(4'hb, regs[3]);
    m_u.send(4'h2, 8'h68);
    rd(4'ha, {dhi, dlo, 6'h08});
    chk(led, 1'b1);
    $display("test refusals done");
    // Kinds 1..3: acquisition, re-read with trigger-only, test event.
    for (i = 1; i <= 3; i++) begin
      v = (i == 1) ? 8'h01 : (i == 2) ? 8'h12 : 8'h04;
      pe = 1'b1;
      m_u.send(4'h2, v);
      repeat (4) @(negedge clk_i);
      chk(rs, 1'b0);
      if (i == 1) chk(shf, 1'b1);
      pe = 1'b0;
      for (n = 0; n < 20 && rs !== 1'b1; n++) @(negedge clk_i);
      chk(kind, i[1:0]);
      if (i == 3) chk(tc, regs[7] & regs[5]);
      if (v[4]) begin
        for (n = 0; n < 6; n++) begin
          ws = 1'b1;
          @(negedge clk_i);
          ws = 1'b0;
          if (n < 5) @(negedge clk_i);
        end
        for (n = 0; n < 4 && rst !== 1'b1; n++) @(negedge clk_i);
        chk(rst, 1'b1);
      end
      rdone = 1'b1;
      @(negedge clk_i);
      rdone = 1'b0;
      rd(4'ha, {dhi, dlo, 5'h00, v[0]});
      $display("test readout kind %0d done", i);
    end
    for (n = 0; n < 10 && expq.size() > 0; n++) @(negedge clk_i);
    chk(expq.size(), 0);
    results;
  end
endmodule
bind ccfg_regs ccfg_regs_checker chk_u (.*);
